// ---- src/dscg_pkg.sv ----
// deep_sleep_clock_gating: package with register map, field layout,
// reset values, bus carrier structs and block state.
// assumes: AXI4-Lite with 32-bit data and 12-bit byte addresses.
package dscg_pkg;

	// ==========================================================
	// register map, byte addresses
	localparam logic [11:0] DSCG_OFS_RUN_CFG   = 12'h060;
	localparam logic [11:0] DSCG_OFS_RUN_GATE  = 12'h100;
	localparam logic [11:0] DSCG_OFS_SLP_GATE  = 12'h110;
	localparam logic [11:0] DSCG_OFS_DEEP_GATE = 12'h120;
	localparam logic [11:0] DSCG_OFS_IRQ_STAT  = 12'h130;
	localparam logic [11:0] DSCG_OFS_IRQ_EN    = 12'h134;
	localparam logic [11:0] DSCG_OFS_IRQ_CLR   = 12'h138;

	// ==========================================================
	// gating register fields
	localparam int          DSCG_BIT_WDOG      = 3;
	localparam int          DSCG_BIT_HOLD      = 6;
	localparam int          DSCG_BIT_CONV      = 16;
	localparam int          DSCG_BIT_CAN       = 24;
	localparam int          DSCG_RATE_LO       = 8;
	localparam int          DSCG_RATE_HI       = 9;
	localparam logic [31:0] DSCG_GATE_WMASK    = 32'h0101_034B & 32'h0101_0348;
	localparam logic [31:0] DSCG_GATE_RESET    = 32'h0000_0040;
	localparam logic [1:0]  DSCG_RATE_125K     = 2'h0;
	localparam logic [1:0]  DSCG_RATE_250K     = 2'h1;
	localparam logic [1:0]  DSCG_RATE_500K     = 2'h2;
	localparam logic [1:0]  DSCG_RATE_MAX      = DSCG_RATE_500K;

	// run-mode configuration: automatic gating select
	localparam int          DSCG_BIT_AUTO_GATE = 27;
	localparam logic        DSCG_AUTO_RESET    = 1'b0;

	// units: 0 watchdog, 1 power hold, 2 converter, 3 can
	localparam int          DSCG_UNITS         = 4;
	localparam logic [3:0]  DSCG_IRQ_RESET     = 4'h0;

	// AXI responses
	localparam logic [1:0]  DSCG_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  DSCG_RESP_SLVERR   = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		DSCG_MODE_RUN,
		DSCG_MODE_SLEEP,
		DSCG_MODE_DEEP
	} dscg_mode_t;

	typedef enum logic [2:0] {
		DSCG_REG_NONE,
		DSCG_REG_RUN_CFG,
		DSCG_REG_RUN_GATE,
		DSCG_REG_SLP_GATE,
		DSCG_REG_DEEP_GATE,
		DSCG_REG_IRQ_STAT,
		DSCG_REG_IRQ_EN,
		DSCG_REG_IRQ_CLR
	} dscg_reg_t;

	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} dscg_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dscg_axi_rsp_t;

	typedef struct packed {
		logic        aw_full;
		logic [11:0] aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        auto_gate;
		logic [31:0] run_gate;
		logic [31:0] slp_gate;
		logic [31:0] deep_gate;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_en;
	} dscg_state_t;

endpackage

// ---- src/dscg_top.sv ----
// deep_sleep_clock_gating: clock gating control with AXI4-Lite
// registers, mode selection of the gating word, fault interrupt.
// assumes: pwr_mode and access_req are synchronous to sys_clk.
//
// Summary of operation
// - set gate bit clocks unit, clear stops it
// - access to gated-off unit raises bus fault
// - gate bits start cleared except bit 6, set in run, sleep and deep
// - deep gate at 0x120, resets 0x00000040
// - run, sleep, deep registers chosen by mode
// - sleep/deep registers used only with auto-gating
// - bit 24 gates can controller
// - bit 16 gates converter, gated access faults
// - bit 6 gates power hold unit
// - bit 3 gates watchdog, gated access faults
// - bits 9:8 pick converter sample rate
// - converter never runs above maximum rate
// - reserved bits read zero, writes ignored
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module dscg_top
	import dscg_pkg::*;
(
	// clock and reset
	input  wire logic           sys_clk,
	input  wire logic           nrst,
	// register bus
	input  wire dscg_axi_req_t  axi_req,
	output dscg_axi_rsp_t       axi_rsp,
	// operating mode
	input  wire dscg_mode_t     pwr_mode,
	// peripheral accesses, one bit per unit
	input  wire logic [3:0]     access_req,
	output logic [3:0]          access_fault,
	// unit clock enables and enables
	output logic [3:0]          unit_clk_en,
	output logic [3:0]          unit_en,
	output logic [1:0]          converter_sample_rate,
	output logic                auto_gating_select,
	// interrupt
	output logic                irq
);

	// ==========================================================
	// helpers
	function automatic dscg_reg_t decode(input logic [11:0] addr);
		dscg_reg_t r;
		r = DSCG_REG_NONE;
		case ({addr[11:2], 2'b00})
			DSCG_OFS_RUN_CFG:   r = DSCG_REG_RUN_CFG;
			DSCG_OFS_RUN_GATE:  r = DSCG_REG_RUN_GATE;
			DSCG_OFS_SLP_GATE:  r = DSCG_REG_SLP_GATE;
			DSCG_OFS_DEEP_GATE: r = DSCG_REG_DEEP_GATE;
			DSCG_OFS_IRQ_STAT:  r = DSCG_REG_IRQ_STAT;
			DSCG_OFS_IRQ_EN:    r = DSCG_REG_IRQ_EN;
			DSCG_OFS_IRQ_CLR:   r = DSCG_REG_IRQ_CLR;
			default:            r = DSCG_REG_NONE;
		endcase
		return r;
	endfunction

	// byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// keep only implemented bits and limit the rate to its maximum
	function automatic logic [31:0] gate_word(input logic [31:0] v);
		logic [31:0] w;
		w = v & DSCG_GATE_WMASK;
		if (w[DSCG_RATE_HI:DSCG_RATE_LO] > DSCG_RATE_MAX) begin
			w[DSCG_RATE_HI:DSCG_RATE_LO] = DSCG_RATE_MAX;
		end
		return w;
	endfunction

	// unit gate bits of a gating word, unit order of the ports
	function automatic logic [3:0] unit_bits(input logic [31:0] v);
		return {v[DSCG_BIT_CAN],
			v[DSCG_BIT_CONV],
			v[DSCG_BIT_HOLD],
			v[DSCG_BIT_WDOG]};
	endfunction

	// ==========================================================
	// state
	dscg_state_t state;
	dscg_state_t next_state;

	// combinational terms
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_go;
	dscg_reg_t   wr_reg;
	dscg_reg_t   rd_reg;
	logic [31:0] active_gate;
	logic [3:0]  gate_bits;
	logic [3:0]  fault_ev;
	logic [31:0] cfg_old;
	logic [31:0] cfg_new;

	// ==========================================================
	// handshakes
	assign axi_rsp.awready = ~state.aw_full & ~state.bvalid;
	assign axi_rsp.wready  = ~state.w_full & ~state.bvalid;
	assign axi_rsp.arready = ~state.rvalid;
	assign axi_rsp.bvalid  = state.bvalid;
	assign axi_rsp.bresp   = state.bresp;
	assign axi_rsp.rvalid  = state.rvalid;
	assign axi_rsp.rdata   = state.rdata;
	assign axi_rsp.rresp   = state.rresp;

	assign aw_take = axi_req.awvalid & axi_rsp.awready;
	assign w_take  = axi_req.wvalid & axi_rsp.wready;
	assign ar_take = axi_req.arvalid & axi_rsp.arready;

	assign wr_addr = state.aw_full ? state.aw_addr : axi_req.awaddr;
	assign wr_data = state.w_full ? state.w_data : axi_req.wdata;
	assign wr_strb = state.w_full ? state.w_strb : axi_req.wstrb;
	assign wr_go   = (state.aw_full | aw_take) & (state.w_full | w_take);
	assign wr_reg  = decode(wr_addr);
	assign rd_reg  = decode(axi_req.araddr);

	// run configuration word as software sees it, merged with a write
	always_comb begin
		cfg_old                     = 32'h0000_0000;
		cfg_old[DSCG_BIT_AUTO_GATE] = state.auto_gate;
	end
	assign cfg_new = merge(cfg_old, wr_data, wr_strb);

	// ==========================================================
	// mode selection of the gating word
	always_comb begin
		active_gate = state.run_gate;
		if (state.auto_gate) begin
			case (pwr_mode)
				DSCG_MODE_RUN:   active_gate = state.run_gate;
				DSCG_MODE_SLEEP: active_gate = state.slp_gate;
				DSCG_MODE_DEEP:  active_gate = state.deep_gate;
				default:         active_gate = state.run_gate;
			endcase
		end
	end

	assign gate_bits             = unit_bits(active_gate);
	assign converter_sample_rate =
		active_gate[DSCG_RATE_HI:DSCG_RATE_LO];
	assign auto_gating_select    = state.auto_gate;

	// ==========================================================
	// per-unit gates
	genvar gi;
	generate
		for (gi = 0; gi < DSCG_UNITS; gi++) begin : g_unit
			dscg_unit_gate u_gate (
				.gate_on      (gate_bits[gi]),
				.access_req   (access_req[gi]),
				.clk_en       (unit_clk_en[gi]),
				.unit_en      (unit_en[gi]),
				.access_fault (fault_ev[gi])
			);
		end
	endgenerate

	assign access_fault = fault_ev;

	// ==========================================================
	// interrupt
	assign irq = |(state.irq_stat & state.irq_en);

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;

		// write address and data are latched independently
		if (aw_take) begin
			next_state.aw_full = 1'b1;
			next_state.aw_addr = axi_req.awaddr;
		end
		if (w_take) begin
			next_state.w_full = 1'b1;
			next_state.w_data = axi_req.wdata;
			next_state.w_strb = axi_req.wstrb;
		end
		if (state.bvalid && axi_req.bready) begin
			next_state.bvalid = 1'b0;
		end

		// sticky fault bits; a new event beats a clear
		next_state.irq_stat = state.irq_stat | fault_ev;

		if (wr_go) begin
			next_state.aw_full = 1'b0;
			next_state.w_full  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = DSCG_RESP_OKAY;
			case (wr_reg)
				DSCG_REG_RUN_CFG: begin
					next_state.auto_gate = cfg_new[DSCG_BIT_AUTO_GATE];
				end
				DSCG_REG_RUN_GATE: begin
					next_state.run_gate = gate_word(
						merge(state.run_gate, wr_data, wr_strb));
				end
				DSCG_REG_SLP_GATE: begin
					next_state.slp_gate = gate_word(
						merge(state.slp_gate, wr_data, wr_strb));
				end
				DSCG_REG_DEEP_GATE: begin
					next_state.deep_gate = gate_word(
						merge(state.deep_gate, wr_data, wr_strb));
				end
				DSCG_REG_IRQ_STAT: begin
					// read-only, write ignored
					next_state.bresp = DSCG_RESP_OKAY;
				end
				DSCG_REG_IRQ_EN: begin
					if (wr_strb[0]) begin
						next_state.irq_en = wr_data[3:0];
					end
				end
				DSCG_REG_IRQ_CLR: begin
					if (wr_strb[0]) begin
						next_state.irq_stat =
							(state.irq_stat & ~wr_data[3:0]) | fault_ev;
					end
				end
				default: begin
					next_state.bresp = DSCG_RESP_SLVERR;
				end
			endcase
		end

		// reads answer one cycle after the address is taken
		if (state.rvalid && axi_req.rready) begin
			next_state.rvalid = 1'b0;
		end
		if (ar_take) begin
			next_state.rvalid = 1'b1;
			next_state.rresp  = DSCG_RESP_OKAY;
			next_state.rdata  = 32'h0000_0000;
			case (rd_reg)
				DSCG_REG_RUN_CFG: begin
					next_state.rdata[DSCG_BIT_AUTO_GATE] = state.auto_gate;
				end
				DSCG_REG_RUN_GATE: begin
					next_state.rdata = state.run_gate;
				end
				DSCG_REG_SLP_GATE: begin
					next_state.rdata = state.slp_gate;
				end
				DSCG_REG_DEEP_GATE: begin
					next_state.rdata = state.deep_gate;
				end
				DSCG_REG_IRQ_STAT: begin
					next_state.rdata[3:0] = state.irq_stat;
				end
				DSCG_REG_IRQ_EN: begin
					next_state.rdata[3:0] = state.irq_en;
				end
				DSCG_REG_IRQ_CLR: begin
					// write-only, reads zero
					next_state.rdata = 32'h0000_0000;
				end
				default: begin
					next_state.rresp = DSCG_RESP_SLVERR;
				end
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state           <= '0;
			state.auto_gate <= DSCG_AUTO_RESET;
			state.run_gate  <= DSCG_GATE_RESET;
			state.slp_gate  <= DSCG_GATE_RESET;
			state.deep_gate <= DSCG_GATE_RESET;
			state.irq_stat  <= DSCG_IRQ_RESET;
			state.irq_en    <= DSCG_IRQ_RESET;
		end else begin
			state <= next_state;
		end
	end

endmodule

// ---- src/dscg_unit_gate.sv ----
// deep_sleep_clock_gating: gate of one peripheral unit.
// assumes: access_req is high in the cycle the peripheral bus
// presents an access to the unit.
`timescale 1ns/10ps
module dscg_unit_gate
	import dscg_pkg::*;
(
	// gate control
	input  wire logic gate_on,
	// peripheral side
	input  wire logic access_req,
	output logic      clk_en,
	output logic      unit_en,
	output logic      access_fault
);

	// ==========================================================
	// clock and fault
	assign clk_en       = gate_on;
	assign unit_en      = gate_on;
	assign access_fault = access_req & ~gate_on;

endmodule

// ---- tb/dscg_properties.sv ----
// deep_sleep_clock_gating: port assertions of dscg_top.
// assumes: bound to dscg_top, single sys_clk domain.
`timescale 1ns/10ps
module dscg_properties
	import dscg_pkg::*;
(
	// clock and reset
	input wire logic          sys_clk,
	input wire logic          nrst,
	// register bus
	input wire dscg_axi_req_t axi_req,
	input wire dscg_axi_rsp_t axi_rsp,
	// mode and units
	input wire dscg_mode_t    pwr_mode,
	input wire logic [3:0]    access_req,
	input wire logic [3:0]    access_fault,
	input wire logic [3:0]    unit_clk_en,
	input wire logic [3:0]    unit_en,
	input wire logic [1:0]    converter_sample_rate,
	input wire logic          auto_gating_select,
	input wire logic          irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// bus steps
	sequence s_ar_take;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	sequence s_r_out;
		axi_rsp.rvalid && !axi_rsp.arready;
	endsequence

	a_fault_gate: assert property (
		access_fault == (access_req & ~unit_clk_en))
		else $error("fault does not follow gating");
	a_unit_enable: assert property (unit_en == unit_clk_en)
		else $error("unit enable differs from clock enable");
	a_rate_max: assert property (converter_sample_rate != 2'h3)
		else $error("sample rate above maximum");
	a_gate_cause: assert property ($changed(unit_clk_en) |->
		$rose(axi_rsp.bvalid) || (auto_gating_select && $changed(pwr_mode)))
		else $error("gating changed without cause");
	a_irq_rise: assert property ($rose(irq) |->
		$past(|access_fault) || $rose(axi_rsp.bvalid))
		else $error("interrupt rose without event");
	a_irq_fall: assert property ($fell(irq) |-> $rose(axi_rsp.bvalid))
		else $error("interrupt fell without write");
	a_read_answer: assert property (s_ar_take |=> s_r_out)
		else $error("read answer late");
	a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data not held");
	a_b_block: assert property (axi_rsp.bvalid |->
		!axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while response pending");
endmodule

// ---- tb/tb.sv ----
// deep_sleep_clock_gating: self-checking bench for dscg_top.
// assumes: AXI4-Lite master and unit accesses driven from here.
`timescale 1ns/10ps
module tb
	import dscg_pkg::*;
;
	logic          sys_clk;
	logic          nrst;
	dscg_axi_req_t req;
	dscg_axi_rsp_t rsp;
	dscg_mode_t    pwr_mode;
	logic [3:0]    access_req;
	logic [3:0]    access_fault;
	logic [3:0]    unit_clk_en;
	logic [3:0]    unit_en;
	logic [1:0]    rate;
	logic          auto_sel;
	logic          irq;
	integer        seed;
	int            errors;
	int            n_tests;
	logic [31:0]   g [3];
	logic          auto;
	logic [31:0]   d;
	logic [31:0]   w;
	logic [1:0]    r;
	logic [1:0]    k;
	logic [11:0]   ad;

	dscg_top dut (
		.sys_clk(sys_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.pwr_mode(pwr_mode), .access_req(access_req),
		.access_fault(access_fault), .unit_clk_en(unit_clk_en),
		.unit_en(unit_en), .converter_sample_rate(rate),
		.auto_gating_select(auto_sel), .irq(irq)
	);

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	function automatic logic [31:0] wval(input logic [31:0] v);
		wval = v & 32'h0101_0348;
		if (wval[9:8] == 2'h3) wval[9:8] = 2'h2;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic aw, wd, b;
		@(posedge sys_clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= v;
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		do begin
			@(negedge sys_clk);
			aw = req.awvalid & rsp.awready;
			wd = req.wvalid & rsp.wready;
			b = rsp.bvalid;
			r = rsp.bresp;
			@(posedge sys_clk);
			if (aw) req.awvalid <= 1'b0;
			if (wd) req.wvalid <= 1'b0;
		end while (!b);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		logic ar, v, rv;
		@(posedge sys_clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		do begin
			@(negedge sys_clk);
			ar = req.arvalid & rsp.arready;
			rv = rsp.rvalid;
			v = rsp.rvalid & req.rready;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge sys_clk);
			if (ar) req.arvalid <= 1'b0;
			// accept one cycle late so held read data is exercised
			if (rv && !v) req.rready <= 1'b1;
		end while (!v);
		req.rready <= 1'b0;
	endtask

	task automatic wrap_up;
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// clock, watchdog
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		wrap_up();
	end

	// ==========================================================
	// scenarios
	initial begin
		seed = 32'h261d8dda;
		nrst = 1'b0;
		req = '0;
		pwr_mode = DSCG_MODE_RUN;
		access_req = 4'h0;
		g = '{default: 32'h0000_0040};
		auto = 1'b0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(12'h120);
		chk("deep_reset", 32'h0000_0040, d);
		chk("clk_en_reset", 32'(4'b0010), 32'(unit_clk_en));
		for (int i = 0; i < 60; i++) begin
			k = 2'($random(seed));
			w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
			if (i == 0) k = 2'h3;
			ad = (k == 2'h0) ? 12'h060 : 12'h0F0 + {6'h0, k, 4'h0};
			wr(ad, w);
			chk("bresp", 32'(DSCG_RESP_OKAY), 32'(r));
			if (k == 2'h0) auto = w[27];
			else g[k - 2'h1] = wval(w);
			rd(ad);
			w = (k == 2'h0) ? {4'h0, auto, 27'h0} : g[k - 2'h1];
			chk("readback", w, d);
			chk("auto_sel", 32'(auto), 32'(auto_sel));
			@(posedge sys_clk);
			pwr_mode <= dscg_mode_t'(2'($unsigned($random(seed)) % 3));
			access_req <= 4'($random(seed));
			@(negedge sys_clk);
			w = auto ? g[pwr_mode] : g[0];
			chk("clk_en", 32'({w[24], w[16], w[6], w[3]}), 32'(unit_clk_en));
			chk("unit_en", 32'({w[24], w[16], w[6], w[3]}), 32'(unit_en));
			chk("rate", 32'(w[9:8]), 32'(rate));
			chk("fault", 32'(access_req & ~{w[24], w[16], w[6], w[3]}),
				32'(access_fault));
			@(posedge sys_clk);
			access_req <= 4'h0;
		end
		wr(12'h200, 32'h1);
		chk("unmapped_bresp", 32'(DSCG_RESP_SLVERR), 32'(r));
		rd(12'h200);
		chk("unmapped_rresp", 32'(DSCG_RESP_SLVERR), 32'(r));
		wr(12'h060, 32'h0);
		wr(12'h100, 32'h0);
		wr(12'h138, 32'hF);
		wr(12'h134, 32'h1);
		@(posedge sys_clk);
		access_req <= 4'h1;
		@(posedge sys_clk);
		access_req <= 4'h0;
		@(negedge sys_clk);
		chk("irq_set", 32'h1, 32'(irq));
		rd(12'h130);
		chk("irq_status", 32'h1, d);
		wr(12'h130, 32'h0);
		chk("status_bresp", 32'(DSCG_RESP_OKAY), 32'(r));
		rd(12'h130);
		chk("status_ro", 32'h1, d);
		rd(12'h138);
		chk("clear_reads_zero", 32'h0, d);
		rd(12'h134);
		chk("irq_enable", 32'h1, d);
		wr(12'h134, 32'h0);
		@(negedge sys_clk);
		chk("irq_masked", 32'h0, 32'(irq));
		wr(12'h134, 32'h1);
		wr(12'h138, 32'h1);
		@(negedge sys_clk);
		chk("irq_cleared", 32'h0, 32'(irq));
		wrap_up();
	end
endmodule

bind dscg_top dscg_properties u_props (
	.sys_clk(sys_clk), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.pwr_mode(pwr_mode), .access_req(access_req),
	.access_fault(access_fault), .unit_clk_en(unit_clk_en),
	.unit_en(unit_en), .converter_sample_rate(converter_sample_rate),
	.auto_gating_select(auto_gating_select), .irq(irq)
);
